// *** sbcsl_bank_state.sv ***
// SDRAM bank command decode and per-bank state tracking.
`timescale 1ns/1ps

module sbcsl_bank_state (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  input  wire logic                          cke,
  input  wire logic                          selfRefreshExit,
  input  wire sbcsl_pkg::sbcsl_bus_t         cmdBus,
  output sbcsl_pkg::sbcsl_result_t           result,
  output sbcsl_pkg::sbcsl_bank_t [3:0]       bankState,
  output logic                               allIdle,
  output logic [3:0]                         readDataBank,
  output logic                               readDataValid,
  output logic [3:0]                         writeDataBank,
  output logic                               writeDataValid,
  output logic                               deepPowerDown
);
  import sbcsl_pkg::*;

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic       ckePrev;
  logic [7:0] xsrCnt;
  logic       rulesLive;
  sbcsl_cmd_t cmd;
  logic [1:0] bankSel;
  logic       apFlag;

  // Gate level seen at the previous edge. It resets low so that the first edge
  // after reset never counts as a second high sample of the gate enable.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev <= 1'b0;
    end else if (clkEn) begin
      ckePrev <= cke;
    end
  end

  // Counts down the exit time after leaving self refresh.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xsrCnt <= 8'h00;
    end else if (clkEn) begin
      if (selfRefreshExit) begin
        xsrCnt <= XSR_CYC;
      end else if (xsrCnt != 8'h00) begin
        xsrCnt <= xsrCnt - 8'h01;
      end
    end
  end

  // Commands are only judged with the gate enable high on two edges in a row
  // and once the exit window after self refresh has run out.
  assign rulesLive = ckePrev && cke && (xsrCnt == 8'h00);
  assign bankSel   = cmdBus.bank;
  assign apFlag    = cmdBus.addr[AP_BIT];

  // A deselected cycle decodes as no-operation, so the strobes are never
  // looked at and nothing in progress is disturbed.
  always_comb begin
    cmd = SBCSL_CMD_NOP;
    if (!cmdBus.csN) begin
      unique case ({cmdBus.rowStrobeN, cmdBus.colStrobeN, cmdBus.writeStrobeN})
        3'b111: cmd = SBCSL_CMD_NOP;
        3'b011: cmd = SBCSL_CMD_ACT;
        3'b101: cmd = SBCSL_CMD_RD;
        3'b100: cmd = SBCSL_CMD_WR;
        3'b010: cmd = SBCSL_CMD_PRE;
        3'b001: cmd = cke ? SBCSL_CMD_REF : SBCSL_CMD_SREF;
        3'b000: cmd = SBCSL_CMD_MRS;
        3'b110: cmd = cke ? SBCSL_CMD_BST : SBCSL_CMD_DPD;
      endcase
    end
  end

  // ==========================================================================
  // Per-bank legality and next state
  // ==========================================================================
  sbcsl_bank_t [3:0] state;
  sbcsl_bank_t [3:0] next_state;
  logic [3:0][7:0]   timer;
  logic [3:0][7:0]   next_timer;
  logic [3:0]        allIdleVec;
  logic              cmdOk;
  logic              isGlobal;
  logic              preAll;

  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      allIdleVec[b] = (state[b] == SBCSL_IDLE);
    end
  end

  assign preAll   = (cmd == SBCSL_CMD_PRE) && apFlag;
  assign isGlobal = (cmd == SBCSL_CMD_REF) || (cmd == SBCSL_CMD_MRS);

  // Decides whether the addressed bank (or all banks) take the command.
  always_comb begin
    cmdOk = 1'b0;
    if (rulesLive) begin
      unique case (cmd)
        SBCSL_CMD_ACT: cmdOk = (state[bankSel] == SBCSL_IDLE);
        SBCSL_CMD_RD,
        SBCSL_CMD_WR:  cmdOk = (state[bankSel] == SBCSL_ACTIVE) ||
                               (state[bankSel] == SBCSL_READ) ||
                               (state[bankSel] == SBCSL_WRITE);
        // Precharge is always taken; the per-bank logic below decides what it
        // does, and an idle bank under a single-bank precharge keeps its state.
        SBCSL_CMD_PRE: cmdOk = 1'b1;
        SBCSL_CMD_REF,
        SBCSL_CMD_MRS: cmdOk = &allIdleVec;
        SBCSL_CMD_BST: cmdOk = (state[bankSel] == SBCSL_READ) ||
                               (state[bankSel] == SBCSL_WRITE);
        default:       cmdOk = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Per-bank state machines
  // ==========================================================================
  // One state machine per bank; bank address picks the one that acts, except that refresh, mode load and precharge with address bit 10 set act on every bank,
  // and a taken read or write also cuts short the bursts in the other banks.
  // Timed states count down first, then a taken command may override them.
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      next_state[b] = state[b];
      next_timer[b] = (timer[b] != 8'h00) ? timer[b] - 8'h01 : 8'h00;
      unique case (state[b])
        SBCSL_ACTVING: begin
          if (timer[b] <= 8'h01) begin
            next_state[b] = SBCSL_ACTIVE;
          end
        end
        SBCSL_PRECHG, SBCSL_GLOBAL: begin
          if (timer[b] <= 8'h01) begin
            next_state[b] = SBCSL_IDLE;
          end
        end
        SBCSL_READ, SBCSL_WRITE: begin
          if (timer[b] <= 8'h01) begin
            next_state[b] = SBCSL_ACTIVE;
          end
        end
        SBCSL_READ_AP, SBCSL_WRITE_AP: begin
          if (timer[b] <= 8'h01) begin
            next_state[b] = SBCSL_IDLE;
          end
        end
        default: begin
        end
      endcase
      if (cmdOk) begin
        if (isGlobal) begin
          next_state[b] = SBCSL_GLOBAL;
          next_timer[b] = (cmd == SBCSL_CMD_REF) ? REFRESH_CYC : MODE_CYC;
        end else if (cmd == SBCSL_CMD_PRE && (preAll || bankSel == 2'(b))) begin
          if (state[b] == SBCSL_ACTIVE || state[b] == SBCSL_READ ||
              state[b] == SBCSL_WRITE) begin
            next_state[b] = SBCSL_PRECHG;
            next_timer[b] = PRECHARGE_CYC;
          end else if (state[b] == SBCSL_IDLE && preAll) begin
            next_state[b] = SBCSL_GLOBAL;
            next_timer[b] = PRECHARGE_CYC;
          end
          // An idle bank under a single-bank precharge is left as it is.
        end else if (bankSel == 2'(b)) begin
          unique case (cmd)
            SBCSL_CMD_ACT: begin
              next_state[b] = SBCSL_ACTVING;
              next_timer[b] = ACTIVATE_CYC;
            end
            SBCSL_CMD_RD: begin
              next_state[b] = apFlag ? SBCSL_READ_AP : SBCSL_READ;
              next_timer[b] = apFlag ? BURST_CYC + PRECHARGE_CYC : BURST_CYC;
            end
            SBCSL_CMD_WR: begin
              next_state[b] = apFlag ? SBCSL_WRITE_AP : SBCSL_WRITE;
              next_timer[b] = apFlag ? BURST_CYC + PRECHARGE_CYC : BURST_CYC;
            end
            SBCSL_CMD_BST: begin
              next_state[b] = SBCSL_ACTIVE;
              next_timer[b] = 8'h00;
            end
            default: begin
            end
          endcase
        end else if ((cmd == SBCSL_CMD_RD || cmd == SBCSL_CMD_WR) &&
                     (state[b] == SBCSL_READ || state[b] == SBCSL_WRITE)) begin
          // A burst on another bank cuts this bank's burst short.
          next_state[b] = SBCSL_ACTIVE;
          next_timer[b] = 8'h00;
        end else if ((cmd == SBCSL_CMD_RD || cmd == SBCSL_CMD_WR) &&
                     (state[b] == SBCSL_READ_AP || state[b] == SBCSL_WRITE_AP) &&
                     timer[b] > PRECHARGE_CYC) begin
          // Interrupted auto-precharge burst starts its precharge now.
          next_timer[b] = PRECHARGE_CYC;
        end
      end
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  // A low clock enable freezes every bank and its timer as they stand.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{default: SBCSL_IDLE};
      timer <= '0;
    end else if (clkEn) begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic [READ_LATENCY-1:0][3:0] rdPipe;
  logic [READ_LATENCY-1:0]      rdPipeValid;
  logic [3:0]                   rdBankOne;

  // One-hot owner of the addressed bank, shared by the read and write paths.
  assign rdBankOne = 4'h1 << bankSel;

  // Result and bank state are registered copies of this edge's decisions, so
  // they show the command of the previous enabled edge until the next enabled edge.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result    <= '{accepted: 1'b0, cmd: SBCSL_CMD_NOP, bank: 2'h0, autoPre: 1'b0};
      bankState <= '{default: SBCSL_IDLE};
      allIdle   <= 1'b1;
    end else if (clkEn) begin
      result.accepted <= cmdOk;
      result.cmd      <= cmd;
      result.bank     <= bankSel;
      result.autoPre  <= apFlag;
      bankState       <= next_state;
      allIdle         <= (next_state == {NUM_BANKS{SBCSL_IDLE}});
    end
  end

  // Read data owner appears one read latency after the read is taken.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdPipe      <= '0;
      rdPipeValid <= '0;
    end else if (clkEn) begin
      rdPipe[0]      <= rdBankOne;
      rdPipeValid[0] <= cmdOk && (cmd == SBCSL_CMD_RD);
      for (int i = 1; i < READ_LATENCY; i++) begin
        rdPipe[i]      <= rdPipe[i-1];
        rdPipeValid[i] <= rdPipeValid[i-1];
      end
    end
  end


  // The owner holds after the burst; the valid level drops once a taken
  // write, burst stop or precharge ends the read data stream.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readDataBank  <= 4'h0;
      readDataValid <= 1'b0;
    end else if (clkEn) begin
      if (rdPipeValid[READ_LATENCY-1]) begin
        readDataBank  <= rdPipe[READ_LATENCY-1];
        readDataValid <= 1'b1;
      end else if (cmdOk && (cmd == SBCSL_CMD_WR || cmd == SBCSL_CMD_BST ||
                             cmd == SBCSL_CMD_PRE)) begin
        readDataValid <= 1'b0;
      end
    end
  end

  // Write data is taken in the cycle of the write command; any later command
  // that ends the burst stops capture, so the previous word was the last.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      writeDataBank  <= 4'h0;
      writeDataValid <= 1'b0;
    end else if (clkEn) begin
      if (cmdOk && cmd == SBCSL_CMD_WR) begin
        writeDataBank  <= rdBankOne;
        writeDataValid <= 1'b1;
      end else if (cmdOk && (cmd == SBCSL_CMD_RD || cmd == SBCSL_CMD_BST ||
                             cmd == SBCSL_CMD_PRE)) begin
        writeDataValid <= 1'b0;
      end
    end
  end


  // Deep power-down is entered only from all banks idle with the gate enable
  // falling, and is left as soon as the gate enable is seen high again.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deepPowerDown <= 1'b0;
    end else if (clkEn) begin
      if (ckePrev && cmd == SBCSL_CMD_DPD && (&allIdleVec)) begin
        deepPowerDown <= 1'b1;
      end else if (cke) begin
        deepPowerDown <= 1'b0;
      end
    end
  end

endmodule

// *** sbcsl_pkg.sv ***
// Package of constants and types for the SDRAM bank command state logic.
package sbcsl_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS            = 50;
  localparam int PRECHARGE_TIME_NS        = 20;
  localparam int ACTIVATE_TO_ACCESS_NS    = 20;
  localparam int REFRESH_CYCLE_TIME_NS    = 80;
  localparam int MODE_LOAD_TIME_NS        = 100;
  localparam int SELF_REFRESH_EXIT_NS     = 120;
  localparam int BURST_LENGTH             = 4;
  localparam int READ_LATENCY             = 3;

  function automatic int cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] PRECHARGE_CYC = 8'(cyc(PRECHARGE_TIME_NS));
  localparam logic [7:0] ACTIVATE_CYC  = 8'(cyc(ACTIVATE_TO_ACCESS_NS));
  localparam logic [7:0] REFRESH_CYC   = 8'(cyc(REFRESH_CYCLE_TIME_NS));
  localparam logic [7:0] MODE_CYC      = 8'(cyc(MODE_LOAD_TIME_NS));
  localparam logic [7:0] XSR_CYC       = 8'(cyc(SELF_REFRESH_EXIT_NS));
  localparam logic [7:0] BURST_CYC     = 8'(BURST_LENGTH);

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_BANKS = 4;
  localparam int AP_BIT    = 10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [8:0] {
    SBCSL_IDLE     = 9'h001,
    SBCSL_ACTVING  = 9'h002,
    SBCSL_ACTIVE   = 9'h004,
    SBCSL_READ     = 9'h008,
    SBCSL_WRITE    = 9'h010,
    SBCSL_READ_AP  = 9'h020,
    SBCSL_WRITE_AP = 9'h040,
    SBCSL_PRECHG   = 9'h080,
    SBCSL_GLOBAL   = 9'h100
  } sbcsl_bank_t;

  typedef enum logic [3:0] {
    SBCSL_CMD_NOP  = 4'h0,
    SBCSL_CMD_ACT  = 4'h1,
    SBCSL_CMD_RD   = 4'h2,
    SBCSL_CMD_WR   = 4'h3,
    SBCSL_CMD_PRE  = 4'h4,
    SBCSL_CMD_REF  = 4'h5,
    SBCSL_CMD_MRS  = 4'h6,
    SBCSL_CMD_BST  = 4'h7,
    SBCSL_CMD_SREF = 4'h8,
    SBCSL_CMD_DPD  = 4'h9
  } sbcsl_cmd_t;

  typedef struct packed {
    logic        csN;
    logic        rowStrobeN;
    logic        colStrobeN;
    logic        writeStrobeN;
    logic [1:0]  bank;
    logic [12:0] addr;
  } sbcsl_bus_t;

  typedef struct packed {
    logic       accepted;
    sbcsl_cmd_t cmd;
    logic [1:0] bank;
    logic       autoPre;
  } sbcsl_result_t;

endpackage

// *** sbcsl_bank_state_sva.sv ***
// Concurrent checks on the ports of the bank command state logic.
`timescale 1ns/1ps
module sbcsl_bank_state_sva (
  input wire logic                          mclk,
  input wire logic                          rst_n,
  input wire logic                          clkEn,
  input wire logic                          cke,
  input wire logic                          selfRefreshExit,
  input wire sbcsl_pkg::sbcsl_bus_t         cmdBus,
  input wire sbcsl_pkg::sbcsl_result_t      result,
  input wire sbcsl_pkg::sbcsl_bank_t [3:0]  bankState,
  input wire logic                          allIdle,
  input wire logic                          deepPowerDown
);
  import sbcsl_pkg::*;
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic       ckePrev;
  logic [7:0] xsr;
  logic [2:0] strobes;
  logic       cmdOk;
  // Tracks the previous gate level and the self refresh exit window.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ckePrev <= 1'b0;
      xsr     <= 8'h00;
    end else if (clkEn) begin
      ckePrev <= cke;
      xsr     <= selfRefreshExit ? XSR_CYC : ((xsr != 8'h00) ? xsr - 8'h01 : xsr);
    end
  end
  assign strobes = {cmdBus.rowStrobeN, cmdBus.colStrobeN, cmdBus.writeStrobeN};
  assign cmdOk   = clkEn && !cmdBus.csN && cke && ckePrev && (xsr == 8'h00);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_inhibit_ignored: assert property (clkEn && cmdBus.csN |=> !result.accepted)
    else $error("Deselected cycle was accepted.");
  a_nop_ignored: assert property (clkEn && !cmdBus.csN && strobes == 3'b111 |=> !result.accepted)
    else $error("No-operation was accepted.");
  a_activate_idle: assert property (cmdOk && strobes == 3'b011 && bankState[cmdBus.bank] == SBCSL_IDLE
    |=> result.accepted && bankState[$past(cmdBus.bank)] == SBCSL_ACTVING)
    else $error("Activate to an idle bank not taken.");
  a_pre_idle_kept: assert property (cmdOk && strobes == 3'b010 && !cmdBus.addr[10]
    && bankState[cmdBus.bank] == SBCSL_IDLE |=> bankState[$past(cmdBus.bank)] == SBCSL_IDLE)
    else $error("Precharge to an idle bank changed it.");
  a_activate_time: assert property (clkEn && bankState[0] == SBCSL_ACTVING |=> bankState[0] == SBCSL_ACTIVE)
    else $error("Bank 0 did not become active in time.");
  a_precharge_time: assert property (clkEn && bankState[0] == SBCSL_PRECHG |=> bankState[0] == SBCSL_IDLE)
    else $error("Bank 0 did not become idle in time.");
  a_read_start: assert property (cmdOk && strobes == 3'b101 && !cmdBus.addr[10]
    && bankState[cmdBus.bank] == SBCSL_ACTIVE |=> bankState[$past(cmdBus.bank)] == SBCSL_READ)
    else $error("Read on an active bank did not start a burst.");
  a_stop_active: assert property (cmdOk && strobes == 3'b110 && bankState[0] == SBCSL_WRITE
    |=> bankState[0] == SBCSL_ACTIVE)
    else $error("Burst stop did not end the write burst.");
  a_refresh_time: assert property (result.accepted && result.cmd == SBCSL_CMD_REF
    |-> !allIdle ##[1:3] allIdle)
    else $error("Refresh did not return to all idle in time.");
  a_dpd_entry: assert property (clkEn && !cmdBus.csN && strobes == 3'b110 && ckePrev && !cke
    && allIdle |-> ##[1:2] deepPowerDown)
    else $error("Deep power-down was not entered.");
endmodule

// *** sbcsl_ctrl_model.sv ***
// Memory controller model that turns command requests into strobe levels.
`timescale 1ns/1ps
module sbcsl_ctrl_model (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   selN,
  input  wire sbcsl_pkg::sbcsl_cmd_t  cmd,
  input  wire logic [1:0]             bank,
  input  wire logic [12:0]            addr,
  output sbcsl_pkg::sbcsl_bus_t       cmdBus
);
  import sbcsl_pkg::*;
  logic [17:0] junk;
  logic [2:0]  strobes;
  // Deselected lines carry a pattern that changes every cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      junk <= 18'h15a5a;
    end else begin
      junk <= junk + 18'h13c71;
    end
  end
  // Only listed command encodings are ever produced.
  always_comb begin
    case (cmd)
      SBCSL_CMD_ACT: strobes = 3'b011;
      SBCSL_CMD_RD:  strobes = 3'b101;
      SBCSL_CMD_WR:  strobes = 3'b100;
      SBCSL_CMD_PRE: strobes = 3'b010;
      SBCSL_CMD_REF: strobes = 3'b001;
      SBCSL_CMD_MRS: strobes = 3'b000;
      SBCSL_CMD_BST: strobes = 3'b110;
      default:       strobes = 3'b111;
    endcase
  end
  assign cmdBus = selN ? sbcsl_bus_t'({1'b1, junk}) : sbcsl_bus_t'({1'b0, strobes, bank, addr});
endmodule

// *** sbcsl_bank_state_tb.sv ***
// Self-checking bench for the bank command state logic.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module sbcsl_bank_state_tb;
  import sbcsl_pkg::*;
  logic                mclk, rst_n, clkEn, cke, selfRefreshExit, selN;
  sbcsl_cmd_t          cmd;
  logic [1:0]          bank;
  logic [12:0]         addr;
  sbcsl_bus_t          cmdBus;
  sbcsl_result_t       result;
  sbcsl_bank_t [3:0]   bankState;
  logic                allIdle, rdValid, wrValid, dpd;
  logic [3:0]          rdBank, wrBank;
  int                  n_mismatch, total_checks;
  sbcsl_ctrl_model i_ctrl (.mclk(mclk), .rst_n(rst_n), .selN(selN), .cmd(cmd), .bank(bank),
    .addr(addr), .cmdBus(cmdBus));
  sbcsl_bank_state i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .cke(cke),
    .selfRefreshExit(selfRefreshExit), .cmdBus(cmdBus), .result(result), .bankState(bankState),
    .allIdle(allIdle), .readDataBank(rdBank), .readDataValid(rdValid), .writeDataBank(wrBank),
    .writeDataValid(wrValid), .deepPowerDown(dpd));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic issue(input sbcsl_cmd_t c, input logic [1:0] b, input logic [12:0] a);
    cmd = c;
    bank = b;
    addr = a;
    @(posedge mclk);
    #2;
    cmd = SBCSL_CMD_NOP;
  endtask
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #2;
    end
  endtask
  task automatic s_basic();
    selN = 1'b1;
    issue(SBCSL_CMD_ACT, 2'h0, 13'h0000);
    selN = 1'b0;
    `CHK("inhibit", 1'b0, result.accepted)
    `CHK("inhibit bank", SBCSL_IDLE, bankState[0])
    issue(SBCSL_CMD_NOP, 2'h0, 13'h0000);
    `CHK("nop", 1'b0, result.accepted)
    issue(SBCSL_CMD_PRE, 2'h1, 13'h0000);
    `CHK("pre idle", SBCSL_IDLE, bankState[1])
  endtask
  task automatic s_same_bank();
    issue(SBCSL_CMD_ACT, 2'h0, 13'h0123);
    `CHK("activating", SBCSL_ACTVING, bankState[0])
    idle(1);
    `CHK("active", SBCSL_ACTIVE, bankState[0])
    issue(SBCSL_CMD_RD, 2'h0, 13'h0004);
    `CHK("read cmd", SBCSL_CMD_RD, result.cmd)
    `CHK("read", SBCSL_READ, bankState[0])
    issue(SBCSL_CMD_WR, 2'h0, 13'h0008);
    `CHK("rd to wr", SBCSL_WRITE, bankState[0])
    issue(SBCSL_CMD_RD, 2'h0, 13'h000c);
    `CHK("wr to rd", SBCSL_READ, bankState[0])
    issue(SBCSL_CMD_WR, 2'h0, 13'h0010);
    issue(SBCSL_CMD_BST, 2'h0, 13'h0000);
    `CHK("stop", SBCSL_ACTIVE, bankState[0])
    issue(SBCSL_CMD_RD, 2'h0, 13'h0000);
    idle(2);
    `CHK("burst held", SBCSL_READ, bankState[0])
    idle(4);
    `CHK("burst done", SBCSL_ACTIVE, bankState[0])
    issue(SBCSL_CMD_WR, 2'h0, 13'h0000);
    issue(SBCSL_CMD_PRE, 2'h0, 13'h0000);
    `CHK("wr cut", SBCSL_PRECHG, bankState[0])
    idle(1);
    `CHK("pre done", SBCSL_IDLE, bankState[0])
  endtask
  task automatic s_other_bank();
    int n;
    issue(SBCSL_CMD_ACT, 2'h0, 13'h0001);
    issue(SBCSL_CMD_ACT, 2'h1, 13'h0002);
    `CHK("act other", SBCSL_ACTVING, bankState[1])
    idle(1);
    issue(SBCSL_CMD_RD, 2'h0, 13'h0000);
    issue(SBCSL_CMD_WR, 2'h1, 13'h0000);
    `CHK("wr other", SBCSL_WRITE, bankState[1])
    `CHK("rd cut", SBCSL_ACTIVE, bankState[0])
    `CHK("wr bank", 2'h1, result.bank)
    `CHK("wr owner", 4'h2, wrBank)
    `CHK("wr valid", 1'b1, wrValid)
    issue(SBCSL_CMD_RD, 2'h0, 13'h0400);
    `CHK("read ap", SBCSL_READ_AP, bankState[0])
    `CHK("ap flag", 1'b1, result.autoPre)
    `CHK("wr stopped", 1'b0, wrValid)
    issue(SBCSL_CMD_RD, 2'h1, 13'h0000);
    `CHK("rd during ap", SBCSL_READ, bankState[1])
    n = 0;
    while (rdBank !== 4'h2 && n < 8) begin
      idle(1);
      n++;
    end
    `CHK("read owner", 4'h2, rdBank)
    `CHK("read valid", 1'b1, rdValid)
    `CHK("ap done", SBCSL_IDLE, bankState[0])
    issue(SBCSL_CMD_PRE, 2'h0, 13'h0400);
    idle(2);
    `CHK("pre all", 1'b1, allIdle)
  endtask
  task automatic s_global();
    issue(SBCSL_CMD_REF, 2'h0, 13'h0000);
    `CHK("refresh", SBCSL_CMD_REF, result.cmd)
    `CHK("refreshing", 1'b0, allIdle)
    issue(SBCSL_CMD_ACT, 2'h2, 13'h0000);
    `CHK("act in refresh", 1'b0, result.accepted)
    idle(3);
    `CHK("refresh done", 1'b1, allIdle)
    issue(SBCSL_CMD_MRS, 2'h0, 13'h0032);
    `CHK("mode load", 1'b0, allIdle)
    idle(3);
    `CHK("mode done", 1'b1, allIdle)
  endtask
  task automatic s_gate();
    cke = 1'b0;
    idle(1);
    cke = 1'b1;
    issue(SBCSL_CMD_ACT, 2'h2, 13'h0000);
    `CHK("gate prev low", 1'b0, result.accepted)
    issue(SBCSL_CMD_ACT, 2'h2, 13'h0000);
    `CHK("gate high", 1'b1, result.accepted)
    clkEn = 1'b0;
    idle(2);
    `CHK("frozen", SBCSL_ACTVING, bankState[2])
    clkEn = 1'b1;
    idle(1);
    issue(SBCSL_CMD_PRE, 2'h2, 13'h0000);
    idle(1);
    selfRefreshExit = 1'b1;
    idle(1);
    selfRefreshExit = 1'b0;
    issue(SBCSL_CMD_ACT, 2'h3, 13'h0000);
    `CHK("exit wait", 1'b0, result.accepted)
    idle(3);
    issue(SBCSL_CMD_ACT, 2'h3, 13'h0000);
    `CHK("exit done", SBCSL_ACTVING, bankState[3])
    idle(1);
    issue(SBCSL_CMD_PRE, 2'h3, 13'h0000);
    idle(1);
    cke = 1'b0;
    issue(SBCSL_CMD_BST, 2'h0, 13'h0000);
    idle(1);
    `CHK("deep pd", 1'b1, dpd)
  endtask
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    cke = 1'b1;
    selfRefreshExit = 1'b0;
    selN = 1'b0;
    cmd = SBCSL_CMD_NOP;
    bank = 2'h0;
    addr = 13'h0000;
    repeat (10) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    idle(2);
    s_basic();
    s_same_bank();
    s_other_bank();
    s_global();
    s_gate();
    give_verdict();
  end
  initial begin
    #200us;
    n_mismatch++;
    give_verdict();
  end
endmodule
bind sbcsl_bank_state sbcsl_bank_state_sva i_sva (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
  .cke(cke), .selfRefreshExit(selfRefreshExit), .cmdBus(cmdBus), .result(result),
  .bankState(bankState), .allIdle(allIdle), .deepPowerDown(deepPowerDown));
